/* hw/pbs_pkg.sv */
// Package: constants and carrier types of the solar boost supervisor
`default_nettype none
package pbs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int PWM_HZ = 100_000;
  localparam int PWM_PERIOD = CLK_HZ / PWM_HZ;
  localparam int PHASES = 4;

  // ----------------------------------------------------------------
  // Duty cycle in steps of 0.2 %, so 500 steps make 100 %
  // ----------------------------------------------------------------
  localparam int DUTY_W = 9;
  localparam int DUTY_FULL = 500;
  localparam logic [DUTY_W-1:0] DUTY_MIN = 9'h019;  // 5 %
  localparam logic [DUTY_W-1:0] DUTY_MAX = 9'h1c2;  // 90 %
  localparam logic [DUTY_W-1:0] DUTY_STEP = 9'h001; // 0.2 %

  // ----------------------------------------------------------------
  // Serial command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RESERVED = 8'h00;
  localparam logic [7:0] CMD_NOP = 8'h01;
  localparam logic [7:0] CMD_SHUT = 8'h02;
  localparam logic [7:0] CMD_TURN_ON = 8'h03;
  localparam logic [7:0] CMD_READ_CURRENT = 8'h04;
  localparam logic [7:0] CMD_READ_VIN = 8'h05;
  localparam logic [7:0] CMD_READ_DUTY = 8'h06;
  localparam logic [7:0] CMD_READ_STATUS = 8'h07;

  // Byte positions inside a frame
  localparam logic [1:0] BYTE_CMD = 2'h0;
  localparam logic [1:0] BYTE_UPPER = 2'h1;
  localparam logic [1:0] BYTE_LOWER = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  localparam int MEAS_W = 10;

  typedef struct packed {
    logic [MEAS_W-1:0] current;
    logic [MEAS_W-1:0] voltage;
  } pbs_meas_t;

  // Status byte, bit 6 down to bit 0
  typedef struct packed {
    logic extra_status_bit;
    logic overtemperature_flag;
    logic overvoltage_flag;
    logic [PHASES-1:0] overcurrent_flags;
  } pbs_status_t;

endpackage
`default_nettype wire

/* hw/pbs_tracker.sv */
// Perturb-and-observe duty tracker of the solar boost supervisor
`default_nettype none
module pbs_tracker (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic restart_i,
  input wire logic step_i,
  input wire pbs_pkg::pbs_meas_t meas_i,
  output logic [pbs_pkg::DUTY_W-1:0] duty_o
);

  // ----------------------------------------------------------------
  // Power and direction
  // ----------------------------------------------------------------
  localparam int PW = 2 * pbs_pkg::MEAS_W;
  logic [PW-1:0] power;
  logic [PW-1:0] prev_power;
  logic dir_up;
  logic next_dir_up;
  logic [pbs_pkg::DUTY_W-1:0] next_duty;
  logic at_max;
  logic at_min;

  // Input power from the latest sample
  assign power = PW'(meas_i.current) * PW'(meas_i.voltage);
  // Keep direction unless power fell, then reverse
  assign next_dir_up = (power >= prev_power) ? dir_up : ~dir_up;
  assign at_max = duty_o >= pbs_pkg::DUTY_MAX - pbs_pkg::DUTY_STEP;
  assign at_min = duty_o <= pbs_pkg::DUTY_MIN + pbs_pkg::DUTY_STEP;
  // Fixed steps, clamped to the window
  assign next_duty = next_dir_up ?
    (at_max ? pbs_pkg::DUTY_MAX : duty_o + pbs_pkg::DUTY_STEP) :
    (at_min ? pbs_pkg::DUTY_MIN : duty_o - pbs_pkg::DUTY_STEP);

  // Restart searches upward from the minimum duty
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_o <= pbs_pkg::DUTY_MIN;
      dir_up <= 1'b1;
      prev_power <= '0;
    end else if (restart_i) begin
      duty_o <= pbs_pkg::DUTY_MIN;
      dir_up <= 1'b1;
      prev_power <= '0;
    end else if (step_i) begin
      duty_o <= next_duty;
      dir_up <= next_dir_up;
      prev_power <= power;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_restart_min: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    restart_i |=> duty_o == pbs_pkg::DUTY_MIN)
    else $error("duty not at minimum after restart");
  a_duty_window: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    duty_o >= pbs_pkg::DUTY_MIN && duty_o <= pbs_pkg::DUTY_MAX)
    else $error("duty outside its window");
  a_duty_step: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    step_i && !restart_i |=> (duty_o == $past(duty_o) + pbs_pkg::DUTY_STEP)
    || (duty_o == $past(duty_o) - pbs_pkg::DUTY_STEP)
    || duty_o == pbs_pkg::DUTY_MIN || duty_o == pbs_pkg::DUTY_MAX)
    else $error("duty moved by more than one step");
  a_dir_follows: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    step_i && !restart_i && power < prev_power
    |=> dir_up != $past(dir_up))
    else $error("direction kept although power fell");
  c_track_step: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    step_i && power < prev_power);

endmodule
`default_nettype wire

/* hw/pbs_supervisor.sv */
// Top of the solar boost supervisor: serial slave, faults, phase drive
//
// Notes on behaviour
// - Overvoltage stops all phases and drives fault output low.
// - After overvoltage clears, restart tracking from minimum duty.
// - Overcurrent turns phase switch off, rectifier on, until next cycle.
// - Overtemperature stops all switches until below release level.
// - Shutdown input high holds converter off with no switching.
// - Undervoltage lockout holds all off and in reset, with hysteresis.
// - Each step compares power; rising keeps direction, falling reverses.
// - Clock idles high; data changes on falling, sampled on rising edge.
// - Every byte travels most significant bit first.
// - Master makes the clock; each byte in shifts one byte out.
// - Select rising inside command byte discards it and closes frame.
// - Bytes may come with pauses or back to back.
// - Wide values right-justified, zero-extended, upper byte first.
// - Code 0 reserved, 1 no-op, 2 shuts down, 3 turns back on.
// - Codes 4, 5, 6 return current, input voltage, duty in two bytes.
// - Code 7 reads four overcurrent, voltage, heat and one extra bit.
// - Duty stays between 5 and 90 percent in 0.2 percent steps.
`default_nettype none
module pbs_supervisor #(
  parameter int PWM_PERIOD = pbs_pkg::PWM_PERIOD
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  input wire logic ovp_cmp_i,
  input wire logic [pbs_pkg::PHASES-1:0] ocp_i,
  input wire logic ot_hot_i,
  input wire logic ot_cool_i,
  input wire logic shutdown_i,
  input wire logic undervoltage_lockout_i,
  input wire logic undervoltage_release_i,
  input wire logic sample_strobe_i,
  input wire pbs_pkg::pbs_meas_t meas_i,
  output logic fault_indicator_n_o,
  output logic [pbs_pkg::PHASES-1:0] low_side_on_o,
  output logic [pbs_pkg::PHASES-1:0] sync_rect_on_o,
  output logic [pbs_pkg::DUTY_W-1:0] duty_o
);

  localparam int CW = $clog2(PWM_PERIOD);
  localparam int NP = pbs_pkg::PHASES;

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  assign rst_n = rst_sync[1];

  // Release reset late so no flop sees a half-released reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  // Pins are asynchronous to clock_i: two flops before any logic
  localparam int SW = 9 + NP;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic sclk_prev;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= {2'h3, {(SW-2){1'b0}}};  // Clock idle high, select high
      pin_sync <= {2'h3, {(SW-2){1'b0}}};
      sclk_prev <= 1'b1;
    end else begin
      pin_meta <= {sclk_i, ss_n_i, mosi_i, ovp_cmp_i, ot_hot_i, ot_cool_i,
                   shutdown_i, undervoltage_lockout_i,
                   undervoltage_release_i, ocp_i};
      pin_sync <= pin_meta;
      sclk_prev <= pin_sync[SW-1];
    end
  end

  logic sclk_s, ss_n_s, mosi_s, ovp_s, hot_s, cool_s, shut_s;
  logic undervoltage_lockout_s, uvrel_s;
  logic [NP-1:0] ocp_s;
  assign {sclk_s, ss_n_s, mosi_s, ovp_s, hot_s, cool_s, shut_s, undervoltage_lockout_s,
          uvrel_s, ocp_s} = pin_sync;

  // ----------------------------------------------------------------
  // Protection state
  // ----------------------------------------------------------------
  logic ot_latched;
  logic undervoltage_lockout_latched;
  logic spi_shut;
  logic run;
  logic restart;

  // Converter runs only with overvoltage, overtemperature, lockout and both shutdowns released
  assign run = !ovp_s && !ot_latched && !shut_s && !spi_shut
               && !undervoltage_lockout_latched;
  assign restart = ovp_s || undervoltage_lockout_latched;

  // Two-level hysteresis keeps the latches from chattering
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ot_latched <= 1'b0;
      undervoltage_lockout_latched <= 1'b1;
    end else begin
      if (hot_s) ot_latched <= 1'b1;
      else if (cool_s) ot_latched <= 1'b0;
      if (undervoltage_lockout_s) undervoltage_lockout_latched <= 1'b1;
      else if (uvrel_s) undervoltage_lockout_latched <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interleaved phase timing
  // ----------------------------------------------------------------
  logic [CW-1:0] pwm_cnt;
  logic [CW-1:0] on_thr;
  logic [NP-1:0] ocp_hold;
  logic [NP-1:0] phase_on;
  logic [NP-1:0] phase_start;
  logic [NP-1:0] ocp_block;

  // Position of phase k inside its own period
  function automatic logic [CW-1:0] phase_cnt(input logic [CW-1:0] c,
                                                input int k);
    logic [CW+1:0] s;
    s = (CW+2)'(c) + (CW+2)'(k * (PWM_PERIOD / NP));
    if (s >= (CW+2)'(PWM_PERIOD)) s = s - (CW+2)'(PWM_PERIOD);
    return s[CW-1:0];
  endfunction

  assign on_thr = CW'((32'(duty_o) * PWM_PERIOD) / pbs_pkg::DUTY_FULL);

  for (genvar k = 0; k < NP; k++) begin : g_phase
    assign phase_on[k] = phase_cnt(pwm_cnt, k) < on_thr;
    assign phase_start[k] = phase_cnt(pwm_cnt, k) == '0;
  end

  // Hold ends on the start count itself, so the phase resumes on time
  assign ocp_block = ocp_s | (ocp_hold & ~phase_start);

  // Overcurrent holds a phase off until its next cycle starts
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt <= '0;
      ocp_hold <= '0;
    end else begin
      pwm_cnt <= (pwm_cnt == CW'(PWM_PERIOD - 1)) ? '0 : pwm_cnt + 1'b1;
      ocp_hold <= ocp_block;
    end
  end

  // Switch drive; while running, the rectifier conducts whenever the switch is off
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      low_side_on_o <= '0;
      sync_rect_on_o <= '0;
      fault_indicator_n_o <= 1'b1;
    end else begin
      low_side_on_o <= run ? phase_on & ~ocp_block : '0;
      sync_rect_on_o <= run ? ~(phase_on & ~ocp_block) : '0;
      fault_indicator_n_o <= !ovp_s;
    end
  end

  // ----------------------------------------------------------------
  // Measurements and tracking
  // ----------------------------------------------------------------
  pbs_pkg::pbs_meas_t meas_hold;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) meas_hold <= '0;
    else if (sample_strobe_i) meas_hold <= meas_i;
  end

  pbs_tracker u_tracker (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .restart_i(restart),
    .step_i(sample_strobe_i && run),
    .meas_i(meas_i),
    .duty_o(duty_o)
  );

  // ----------------------------------------------------------------
  // Serial slave, clock polarity 1 and phase 1
  // ----------------------------------------------------------------
  logic sclk_rise, sclk_fall;
  logic [2:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [6:0] rx_shift;
  logic [7:0] rx_byte;
  logic [7:0] command;
  logic [7:0] tx_shift;
  logic byte_done;
  logic cmd_phase;
  pbs_pkg::pbs_status_t status;

  // Edges judged on synchronised copies only
  assign sclk_rise = !ss_n_s && sclk_s && !sclk_prev;
  assign sclk_fall = !ss_n_s && !sclk_s && sclk_prev;
  assign rx_byte = {rx_shift, mosi_s};  // MSB arrived first
  assign byte_done = sclk_rise && bit_cnt == pbs_pkg::BIT_LAST;
  assign cmd_phase = byte_idx == pbs_pkg::BYTE_CMD;
  assign status = '{extra_status_bit: run, overtemperature_flag: ot_latched,
                    overvoltage_flag: ovp_s,
                    overcurrent_flags: ocp_hold};

  // Read data right-justified in a 16-bit word, zero above
  function automatic logic [15:0] read_word(input logic [7:0] cmd);
    case (cmd)
      pbs_pkg::CMD_READ_CURRENT: read_word = 16'(meas_hold.current);
      pbs_pkg::CMD_READ_VIN: read_word = 16'(meas_hold.voltage);
      pbs_pkg::CMD_READ_DUTY: read_word = 16'(duty_o);
      pbs_pkg::CMD_READ_STATUS: read_word = 16'(status);
      default: read_word = 16'h0000;
    endcase
  endfunction

  // Byte to present next; upper byte first, then lower, then zeros
  logic [7:0] next_tx;
  logic [15:0] word_now;
  assign word_now = read_word(cmd_phase ? rx_byte : command);
  assign next_tx = (cmd_phase || byte_idx == pbs_pkg::BYTE_UPPER) ?
                   (cmd_phase ? word_now[15:8] : word_now[7:0]) :
                   8'h00;

  // Frame state; select high closes the frame and drops partial bits
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= '0;
      byte_idx <= pbs_pkg::BYTE_CMD;
      rx_shift <= '0;
      command <= pbs_pkg::CMD_RESERVED;
    end else if (ss_n_s) begin
      bit_cnt <= '0;
      byte_idx <= pbs_pkg::BYTE_CMD;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 1'b1;  // Pauses between bytes are harmless
      rx_shift <= rx_byte[6:0];
      if (byte_done && cmd_phase) command <= rx_byte;
      if (byte_done && byte_idx != pbs_pkg::BYTE_LOWER)
        byte_idx <= byte_idx + 1'b1;
    end
  end

  // Shut and turn-on commands; lockout clears a pending shut
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) spi_shut <= 1'b0;
    else if (undervoltage_lockout_latched) spi_shut <= 1'b0;
    else if (byte_done && cmd_phase && rx_byte == pbs_pkg::CMD_SHUT)
      spi_shut <= 1'b1;
    else if (byte_done && cmd_phase && rx_byte == pbs_pkg::CMD_TURN_ON)
      spi_shut <= 1'b0;
  end

  // Reply shifter: loaded at byte end, bit out on each falling edge
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift <= '0;
      miso_o <= 1'b0;
    end else if (ss_n_s) begin
      tx_shift <= '0;  // Zeros until a command is known
      miso_o <= 1'b0;
    end else if (byte_done) begin
      tx_shift <= next_tx;  // One byte out per byte
    end else if (sclk_fall) begin
      miso_o <= tx_shift[7];
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ovp_fault_low: assert property (@(posedge clock_i) disable iff (!rst_n)
    ovp_s |=> !fault_indicator_n_o && low_side_on_o == '0)
    else $error("overvoltage did not stop phases or flag fault");
  a_ocp_phase_off: assert property (@(posedge clock_i) disable iff (!rst_n)
    ocp_s[0] && run |=> !low_side_on_o[0] && sync_rect_on_o[0])
    else $error("overcurrent phase not handed to rectifier");
  a_ocp_until_start: assert property (@(posedge clock_i) disable iff (!rst_n)
    ocp_hold[1] && !phase_start[1] |=> !low_side_on_o[1])
    else $error("phase resumed before its next cycle");
  a_ot_hold_off: assert property (@(posedge clock_i) disable iff (!rst_n)
    ot_latched && !cool_s |=> ot_latched && low_side_on_o == '0)
    else $error("overtemperature released early");
  a_shut_no_switch: assert property (@(posedge clock_i) disable iff (!rst_n)
    shut_s [*2] |-> low_side_on_o == '0 && sync_rect_on_o == '0)
    else $error("switching while shut down");
  a_undervoltage_lockout_all_off: assert property (@(posedge clock_i) disable iff (!rst_n)
    undervoltage_lockout_latched |=> low_side_on_o == '0 && !spi_shut)
    else $error("activity during undervoltage lockout");
  a_shut_command: assert property (@(posedge clock_i) disable iff (!rst_n)
    byte_done && cmd_phase && rx_byte == pbs_pkg::CMD_SHUT && !undervoltage_lockout_latched
    |=> spi_shut ##1 low_side_on_o == '0)
    else $error("shut command not obeyed");
  a_cmd_miso_zero: assert property (@(posedge clock_i) disable iff (!rst_n)
    cmd_phase && $past(cmd_phase) |-> !miso_o)
    else $error("data driven during command byte");
  a_frame_abort: assert property (@(posedge clock_i) disable iff (!rst_n)
    ss_n_s |=> bit_cnt == '0 && cmd_phase)
    else $error("partial byte kept after select rose");
  c_read_frame: cover property (@(posedge clock_i) disable iff (!rst_n)
    byte_done && byte_idx == pbs_pkg::BYTE_UPPER);
  c_shut_then_on: cover property (@(posedge clock_i) disable iff (!rst_n)
    $fell(spi_shut));
  c_ocp_event: cover property (@(posedge clock_i) disable iff (!rst_n)
    $rose(ocp_hold[2]));

endmodule
`default_nettype wire

/* tb/pbs_host_model.sv */
// Host-side serial master model driving the supervisor's serial port
`default_nettype none
module pbs_host_model (
  input wire logic clock_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic ss_n_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Clock idles high and moves only inside frames
  initial begin
    sclk_o = 1'b1;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Data line toggles every cycle between frames, so it never holds a stale bit
  always @(posedge clock_i) begin
    if (ss_n_o) begin
      mosi_o <= ~mosi_o;
    end
  end

  // One frame: command byte cut to cbits, then nrd zero bytes
  task automatic frame(input logic [7:0] cmd, input int cbits,
      input int nrd, input int gap, output logic [23:0] rd);
    logic [7:0] tx;
    rd = 24'h000000;
    @(posedge clock_i);
    ss_n_o <= 1'b0; // Held low for the whole frame
    repeat (4) @(posedge clock_i);
    for (int b = 0; b <= nrd; b++) begin
      tx = (b == 0) ? cmd : 8'h00;
      for (int i = 7; i >= 0; i--) begin
        if (b == 0 && 7 - i >= cbits) break;
        sclk_o <= 1'b0;
        mosi_o <= tx[i]; // Top bit first, on falling edge
        repeat (4) @(posedge clock_i);
        sclk_o <= 1'b1;
        rd = {rd[22:0], miso_i}; // One bit back per bit out
        repeat (4) @(posedge clock_i);
      end
      repeat (gap) @(posedge clock_i);
    end
    ss_n_o <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

/* tb/pbs_supervisor_tb.sv */
// Self-checking bench of the solar boost supervisor
`default_nettype none
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("BAD %0t got %h want %h", $time, got, exp); \
    end \
  end
module pbs_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  localparam int PER = 40; // Short switching period keeps runs brief
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ovp = 1'b0;
  logic [3:0] ocp = 4'h0;
  logic ot_hot = 1'b0;
  logic ot_cool = 1'b1;
  logic shut = 1'b0;
  logic uv_lock = 1'b0;
  logic uv_rel = 1'b0;
  logic strobe = 1'b0;
  pbs_pkg::pbs_meas_t meas = 20'h00000;
  logic sclk, ss_n, mosi, miso, fault_n;
  logic [3:0] low_on, rect_on;
  logic [8:0] duty;
  logic [23:0] rd;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;

  // Free-running system clock
  always #25 clock_i = ~clock_i;

  pbs_host_model host (.clock_i(clock_i), .miso_i(miso), .sclk_o(sclk),
    .ss_n_o(ss_n), .mosi_o(mosi));

  pbs_supervisor #(.PWM_PERIOD(PER)) uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .ss_n_i(ss_n),
    .mosi_i(mosi), .miso_o(miso), .ovp_cmp_i(ovp), .ocp_i(ocp),
    .ot_hot_i(ot_hot), .ot_cool_i(ot_cool), .shutdown_i(shut),
    .undervoltage_lockout_i(uv_lock), .undervoltage_release_i(uv_rel),
    .sample_strobe_i(strobe), .meas_i(meas), .fault_indicator_n_o(fault_n),
    .low_side_on_o(low_on), .sync_rect_on_o(rect_on), .duty_o(duty));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
  endtask

  // Cycles of one period in which any low-side switch is on
  task automatic on_count(output int c);
    c = 0;
    repeat (PER) begin
      @(posedge clock_i);
      if (low_on !== 4'h0) c++;
    end
  endtask

  // Bounded wait for the next turn-on of phase 0
  task automatic rise0(output int c);
    c = 0;
    while (low_on[0] !== 1'b0 && c < 2 * PER) begin
      tick(1);
      c++;
    end
    while (low_on[0] !== 1'b1 && c < 2 * PER) begin
      tick(1);
      c++;
    end
  endtask

  // One tracking step with a fresh measurement
  task automatic step(input logic [9:0] cur);
    @(posedge clock_i);
    meas <= {cur, 10'h15a};
    strobe <= 1'b1;
    @(posedge clock_i);
    strobe <= 1'b0;
    tick(2);
  endtask

  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp,
      input int gap);
    host.frame(cmd, 8, 2, gap, rd);
    `CHK(rd, {8'h00, exp})
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK({fault_n, duty}, {1'b1, 9'h019})
    on_count(n);
    `CHK(n, 0)
    uv_rel <= 1'b1;
    tick(6);
    on_count(n);
    `CHK(n, 8)
    $display("reset done");
  endtask

  task automatic t_reads();
    step(10'h2a5);
    rd_chk(8'h04, 16'h02a5, 0);
    rd_chk(8'h05, 16'h015a, 12);
    rd_chk(8'h06, 16'h001a, 0);
    rd_chk(8'h07, 16'h0040, 0);
    $display("reads done");
  endtask

  task automatic t_track();
    logic [9:0] cur [5] = '{10'h300, 10'h100, 10'h100, 10'h100, 10'h080};
    logic [8:0] want [5] = '{9'h01b, 9'h01a, 9'h019, 9'h019, 9'h01a};
    foreach (cur[i]) begin
      step(cur[i]);
      `CHK(duty, want[i])
    end
    repeat (430) step(10'h080);
    `CHK(duty, 9'h1c2)
    $display("tracking done");
  endtask

  task automatic t_ocp();
    rise0(n);
    tick(2);
    ocp <= 4'h7;
    tick(1);
    ocp <= 4'h0;
    tick(3);
    `CHK({low_on[2:0], rect_on[2:0]}, 6'h07)
    rise0(n);
    `CHK(n + 6, PER)
    $display("overcurrent done");
  endtask

  task automatic t_faults();
    ot_hot <= 1'b1;
    ot_cool <= 1'b0;
    tick(5);
    `CHK(low_on, 4'h0)
    host.frame(8'h07, 8, 2, 0, rd);
    `CHK(rd[5], 1'b1)
    ot_hot <= 1'b0;
    on_count(n);
    `CHK(n, 0)
    ot_cool <= 1'b1;
    tick(4);
    on_count(n);
    `CHK(n, PER)
    shut <= 1'b1;
    tick(4);
    on_count(n);
    `CHK(n, 0)
    shut <= 1'b0;
    tick(4);
    on_count(n);
    `CHK(n, PER)
    $display("faults done");
  endtask

  task automatic noops();
    logic [7:0] c [4] = '{8'h00, 8'h01, 8'h08, 8'hff};
    foreach (c[i]) begin
      host.frame(c[i], 8, 2, 0, rd);
      `CHK(rd, 24'h000000)
    end
  endtask

  task automatic t_cmds();
    host.frame(8'h02, 8, 0, 0, rd);
    on_count(n);
    `CHK(n, 0)
    rd_chk(8'h07, 16'h0000, 0);
    noops();
    host.frame(8'h03, 8, 0, 0, rd);
    on_count(n);
    `CHK(n, PER)
    noops();
    on_count(n);
    `CHK(n, PER)
    host.frame(8'h07, 5, 0, 0, rd);
    rd_chk(8'h04, 16'h0080, 0);
    $display("commands done");
  endtask

  task automatic t_ovp();
    ovp <= 1'b1;
    tick(4);
    `CHK({fault_n, low_on}, 5'h00)
    host.frame(8'h07, 8, 2, 0, rd);
    `CHK(rd[4], 1'b1)
    ovp <= 1'b0;
    tick(4);
    `CHK({fault_n, duty}, {1'b1, 9'h019})
    uv_lock <= 1'b1;
    uv_rel <= 1'b0;
    tick(4);
    on_count(n);
    `CHK(n, 0)
    uv_lock <= 1'b0;
    tick(4);
    on_count(n);
    `CHK(n, 0)
    uv_rel <= 1'b1;
    tick(6);
    on_count(n);
    `CHK(n, 8)
    $display("overvoltage and lockout done");
  endtask

  // Hang guard: the full sequence needs well under this many cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    tick(8);
    rst_n_i <= 1'b1;
    tick(6);
    t_reset();
    t_reads();
    t_track();
    t_ocp();
    t_faults();
    t_cmds();
    t_ovp();
    final_report();
  end
endmodule
`default_nettype wire
